// ### cog_clkctl_top.sv
// Serial slave and control registers 0 to 5 of the clock generator.
`timescale 1ns/1ps
module cog_clkctl_top import cog_pkg::*; (
  input wire logic ref_clk, // 125 MHz block clock.
  input wire logic rstn, // Asynchronous power-up reset, active low.
  input wire logic scl_in, // Serial clock pin level.
  input wire logic sda_in, // Serial data pin level.
  input wire logic power_down_pin, // Power-down request pin, high active.
  input wire logic bus_clock_halt_n, // Pci-stop pin, active low.
  input wire logic host_clock_halt_n, // Cpu-stop pin, active low.
  input wire logic sw_bus_halt_n, // Software pci-stop, active low, same clock.
  output logic sda_out, // Serial data drive level, always low.
  output logic sda_oe, // Serial data pull-down enable, high while driving.
  output cog_run_t run // Registered output run and drive controls.
);

  logic [4:0] pins_s;
  logic scl_s, sda_s, power_down_state, bus_halt_s_n, host_halt_s_n;
  logic scl_d, sda_d, pd_d;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  cog_state_t state;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] txsh;
  logic rw;
  logic [6:0] offset;
  logic [7:0] wr_byte;
  logic wr_go;
  logic [7:0] bank [0:COG_NUM_REGS-1];
  logic [7:0] next_bank [0:COG_NUM_REGS-1];
  logic [7:0] rd_byte;
  logic clr_cfg, mode_combo, bus_halt, host_halt;
  cog_run_t next_run;

  // Decodes whether an offset lands on one of the implemented registers.
  function automatic logic reg_hit(input logic [6:0] off);
    reg_hit = (off < 7'(COG_NUM_REGS));
  endfunction

  // Pins reset to their idle levels so no false start is seen after reset.
  cog_sync #(.W(5), .INIT(5'h1B)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din({scl_in, sda_in, power_down_pin, bus_clock_halt_n, host_clock_halt_n}),
    .dout(pins_s)
  );

  assign {scl_s, sda_s, power_down_state, bus_halt_s_n, host_halt_s_n} = pins_s;

  // Delayed copies of the synchronised pins for edge detection.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pd_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      pd_d <= power_down_state;
    end
  end

  // Bus events; start and stop are data edges while the clock is high.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // Read data; offsets past the bank read as zero.
  assign rd_byte = reg_hit(offset) ? bank[offset[2:0]] : 8'h00;

  // Serial slave sequencer. Acknowledge is driven from one clock fall to the next.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= COG_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      txsh <= 8'h00;
      rw <= 1'b0;
      offset <= 7'h00;
      wr_byte <= 8'h00;
      wr_go <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      wr_go <= 1'b0;
      if (start_seen) begin
        // A repeated start restarts address reception at any point.
        state <= COG_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= COG_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == COG_ADDR || state == COG_CMD || state == COG_WDATA) begin
          shift <= {shift[6:0], sda_s};
          cnt <= cnt + 4'h1;
        end
      end else if (scl_fall) begin
        case (state)
          COG_ADDR: begin
            if (cnt == COG_BITS_PER_BYTE) begin
              if (shift[7:1] == COG_DEV_ADDR) begin
                rw <= shift[0];
                sda_oe <= 1'b1;
                state <= COG_ACK_A;
              end else begin
                state <= COG_IGNORE;
              end
            end
          end
          COG_ACK_A: begin
            cnt <= 4'h0;
            if (rw) begin
              // First read bit goes out on the fall that ends the acknowledge.
              sda_oe <= ~rd_byte[7];
              txsh <= {rd_byte[6:0], 1'b0};
              cnt <= 4'h1;
              state <= COG_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= COG_CMD;
            end
          end
          COG_CMD: begin
            if (cnt == COG_BITS_PER_BYTE) begin
              if (shift[COG_CMD_BYTE_BIT]) begin
                offset <= shift[6:0];
                sda_oe <= 1'b1;
                state <= COG_ACK_C;
              end else begin
                // Block transfers are not served and are left unacknowledged.
                state <= COG_IGNORE;
              end
            end
          end
          COG_ACK_C: begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            state <= COG_WDATA;
          end
          COG_WDATA: begin
            if (cnt == COG_BITS_PER_BYTE) begin
              wr_byte <= shift;
              sda_oe <= 1'b1;
              state <= COG_ACK_D;
            end
          end
          COG_ACK_D: begin
            // Commit only once the acknowledge bit is complete.
            sda_oe <= 1'b0;
            wr_go <= reg_hit(offset);
            state <= COG_IGNORE;
          end
          COG_RDATA: begin
            if (cnt == COG_BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              state <= COG_RACK;
            end else begin
              sda_oe <= ~txsh[7];
              txsh <= {txsh[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
          COG_RACK: begin
            // Only one byte is returned; the slave stops after the ninth clock whatever the controller answers.
            state <= COG_IGNORE;
          end
          COG_IDLE, COG_IGNORE: begin
            state <= state;
          end
          default: begin
            state <= COG_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // The data line is only ever pulled low; release is done through the enable.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Power-down entry reloads the power-up values into the bank unless retention is on.
  assign clr_cfg = power_down_state & ~pd_d & ~bank[0][COG_KEEP_CONFIG_ON_SLEEP_BIT];
  // All three power-management pins asserted together request management mode.
  assign mode_combo = power_down_state & ~bus_halt_s_n & ~host_halt_s_n;

  // One register per offset; reserved bits store what is written.
  genvar gi;
  generate
    for (gi = 0; gi < COG_NUM_REGS; gi++) begin : g_bank
      assign next_bank[gi] = (wr_go && offset[2:0] == 3'(gi)) ? wr_byte :
                             clr_cfg ? COG_RST_ALL[gi*8 +: 8] : bank[gi];
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          bank[gi] <= COG_RST_ALL[gi*8 +: 8];
        end else if (gi == 0 && mode_combo) begin
          // The pin request wins over a write of zero in the same cycle.
          bank[gi] <= next_bank[gi] | (8'h01 << COG_MGMT_MODE_SELECT_BIT);
        end else begin
          bank[gi] <= next_bank[gi];
        end
      end
    end
  endgenerate

  // Stop conditions from the pins, and from software for the pci group.
  assign bus_halt = ~bus_halt_s_n | ~sw_bus_halt_n;
  assign host_halt = ~host_halt_s_n;

  // Output controls; every clock stops in power-down regardless of its enable.
  always_comb begin
    next_run.serial_ref_run = {8{~power_down_state}} & bank[1]
                              & ~(bank[4] & {8{bus_halt}});
    next_run.panel_run = ~power_down_state & bank[1][0] & ~(bank[4][0] & bus_halt);
    next_run.dot_run = ~power_down_state & bank[2][COG_VIDEO_DOT_EN_BIT];
    next_run.video_nonspread_run = ~power_down_state & bank[2][COG_VIDEO_DOT_EN_BIT];
    next_run.usb_rate_run = ~power_down_state & bank[2][COG_USB_RATE_EN_BIT];
    next_run.refclk_a_run = ~power_down_state & bank[2][COG_REFCLK_A_EN_BIT];
    next_run.refclk_b_run = ~power_down_state & bank[2][COG_REFCLK_B_EN_BIT];
    next_run.freerun_bus_clk_a_run = ~power_down_state & bank[2][COG_FREERUN_A_EN_BIT]
                                     & ~(bank[5][COG_FREERUN_A_STOP_BIT] & bus_halt);
    next_run.bus_clk_run = {4{~power_down_state}} & bank[3][COG_BUS_CLK_EN_LSB +: 4];
    next_run.host_run = {3{~power_down_state}}
                        & {bank[3][COG_HOST2_EN_BIT], bank[2][COG_HOST1_EN_BIT],
                           bank[2][COG_HOST0_EN_BIT]}
                        & ~(bank[5][COG_HOST_STOP_LSB +: 3] & {3{host_halt}});
    next_run.host_spread_on = bank[2][COG_SPREAD_EN_BIT];
    next_run.panel_hiz = power_down_state & bank[5][COG_PANEL_PD_HIZ_BIT];
    next_run.dot_hiz = power_down_state & bank[5][COG_DOT_PD_HIZ_BIT];
    next_run.mgmt_mode_select = bank[0][COG_MGMT_MODE_SELECT_BIT];
  end

  // Registered so the buffer controls never glitch on decode changes.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run <= '0;
    end else begin
      run <= next_run;
    end
  end

endmodule // cog_clkctl_top

// ### cog_pkg.sv
// Package with the register map, reset values, field positions and types of the clock control bank.
package cog_pkg;

  // Seven-bit serial slave address; the write form of the address byte is 8'hD2.
  localparam logic [6:0] COG_DEV_ADDR = 7'h69;
  // Command byte bit that selects a single-byte access.
  localparam int COG_CMD_BYTE_BIT = 7;
  localparam int COG_NUM_REGS = 6;
  localparam logic [2:0] COG_BIT_COUNT = 3'h0;
  localparam logic [3:0] COG_BITS_PER_BYTE = 4'h8;

  // Register offsets.
  localparam logic [6:0] COG_OFF_MODE_AND_RETENTION = 7'h00;
  localparam logic [6:0] COG_OFF_REFOUT_ENABLES = 7'h01;
  localparam logic [6:0] COG_OFF_MISC_OUTPUT_ENABLES = 7'h02;
  localparam logic [6:0] COG_OFF_BUS_CLOCK_ENABLES = 7'h03;
  localparam logic [6:0] COG_OFF_REFOUT_STOP_ALLOW = 7'h04;
  localparam logic [6:0] COG_OFF_STOP_AND_POWERDOWN_CTL = 7'h05;

  // Power-up values, register 0 in the low byte.
  localparam logic [47:0] COG_RST_ALL = {8'h07, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h01};

  // Register 0 fields.
  localparam int COG_MGMT_MODE_SELECT_BIT = 4;
  localparam int COG_KEEP_CONFIG_ON_SLEEP_BIT = 0;
  // Register 2 fields.
  localparam int COG_FREERUN_A_EN_BIT = 7;
  localparam int COG_VIDEO_DOT_EN_BIT = 6;
  localparam int COG_USB_RATE_EN_BIT = 5;
  localparam int COG_REFCLK_A_EN_BIT = 4;
  localparam int COG_REFCLK_B_EN_BIT = 3;
  localparam int COG_HOST1_EN_BIT = 2;
  localparam int COG_HOST0_EN_BIT = 1;
  localparam int COG_SPREAD_EN_BIT = 0;
  // Register 3 fields.
  localparam int COG_BUS_CLK_EN_LSB = 4;
  localparam int COG_HOST2_EN_BIT = 1;
  // Register 5 fields.
  localparam int COG_PANEL_PD_HIZ_BIT = 7;
  localparam int COG_DOT_PD_HIZ_BIT = 6;
  localparam int COG_FREERUN_A_STOP_BIT = 3;
  localparam int COG_HOST_STOP_LSB = 0;

  // Serial slave states.
  typedef enum logic [3:0] {
    COG_IDLE   = 4'b0000,
    COG_ADDR   = 4'b0001,
    COG_ACK_A  = 4'b0010,
    COG_CMD    = 4'b0011,
    COG_ACK_C  = 4'b0100,
    COG_WDATA  = 4'b0101,
    COG_ACK_D  = 4'b0110,
    COG_RDATA  = 4'b0111,
    COG_RACK   = 4'b1000,
    COG_IGNORE = 4'b1001
  } cog_state_t;

  // Run and drive controls handed to the output buffers.
  typedef struct packed {
    logic [7:0] serial_ref_run;
    logic panel_run;
    logic dot_run;
    logic video_nonspread_run;
    logic usb_rate_run;
    logic refclk_a_run;
    logic refclk_b_run;
    logic freerun_bus_clk_a_run;
    logic [3:0] bus_clk_run;
    logic [2:0] host_run;
    logic host_spread_on;
    logic panel_hiz;
    logic dot_hiz;
    logic mgmt_mode_select;
  } cog_run_t;

endpackage

// ### cog_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module cog_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk, // Block clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [W-1:0] din, // Asynchronous inputs.
  output logic [W-1:0] dout // Synchronised inputs.
);

  logic [W-1:0] meta;

  // The first stage is read only by the second, so a metastable value has a cycle to settle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // cog_sync

// ### cog_clkctl_monitor.sv
// Concurrent checks on the ports of the clock control bank.
`timescale 1ns/1ps
module cog_clkctl_monitor import cog_pkg::*; (
  input wire logic ref_clk, // Block clock.
  input wire logic rstn, // Reset, active low.
  input wire logic scl_in, // Serial clock pin.
  input wire logic sda_in, // Serial data pin.
  input wire logic power_down_pin, // Power-down pin.
  input wire logic bus_clock_halt_n, // Pci-stop pin.
  input wire logic host_clock_halt_n, // Cpu-stop pin.
  input wire logic sw_bus_halt_n, // Software pci-stop.
  input wire logic sda_out, // Data drive level.
  input wire logic sda_oe, // Data pull enable.
  input wire cog_run_t run // Output controls.
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Summaries of the run word, kept as wires so the properties stay short.
  wire run_quiet = (run.serial_ref_run == 8'h00) && (run.host_run == 3'h0) && !run.usb_rate_run;
  wire run_dflt = (run.serial_ref_run == 8'hFF) && (run.host_run == 3'h7) && run.host_spread_on;
  // Six samples cover both synchroniser flops and the run flop with two cycles to spare.
  sequence s_asleep;
    power_down_pin [*6];
  endsequence
  sequence s_awake;
    !power_down_pin [*6];
  endsequence
  // The slave may only pull the data line low.
  chk_drive_low_only: assert property (!sda_out)
    else $error("Data drive level is not low.");
  chk_oe_after_fall: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
    else $error("Data pull began without a recent clock fall.");
  chk_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("Data pull did not stand.");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("Data pull changed while the clock was high.");
  chk_reset_defaults: assert property ($rose(rstn) |-> ##6 run_dflt)
    else $error("Run controls do not show power-up values.");
  chk_sleep_stops: assert property (s_asleep |-> run_quiet)
    else $error("Outputs still run in power-down.");
  chk_awake_driven: assert property (s_awake |-> !run.panel_hiz && !run.dot_hiz)
    else $error("Output tri-stated outside power-down.");
  chk_hiz_needs_pd: assert property ((run.panel_hiz || run.dot_hiz) |->
    $past(power_down_pin, 3) || $past(power_down_pin, 4))
    else $error("Tri-state without a power-down request.");
  // All three power-management pins held together must leave the mode bit set.
  sequence s_mode_pins;
    (power_down_pin && !bus_clock_halt_n && !host_clock_halt_n) [*6];
  endsequence
  chk_mode_by_pins: assert property (s_mode_pins |-> run.mgmt_mode_select)
    else $error("Pin combination did not select management mode.");
endmodule // cog_clkctl_monitor

bind cog_clkctl_top cog_clkctl_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in),
  .sda_in(sda_in), .power_down_pin(power_down_pin), .bus_clock_halt_n(bus_clock_halt_n),
  .host_clock_halt_n(host_clock_halt_n), .sw_bus_halt_n(sw_bus_halt_n), .sda_out(sda_out),
  .sda_oe(sda_oe), .run(run));

// ### cog_smb_host.sv
// Behavioural two-wire bus controller issuing byte writes and byte reads.
`timescale 1ns/1ps
module cog_smb_host #(parameter int H = 10) (
  input wire logic ref_clk, // Bit timing reference.
  input wire logic sda_w, // Resolved data wire, pulled up.
  output logic scl = 1'b1, // Serial clock, idle high.
  output logic pull = 1'b0 // High while pulling data low.
);
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Start, also a repeated start: data falls while the clock is high.
  task automatic st();
    pull <= 1'b0;
    w(H);
    scl <= 1'b1;
    w(H);
    pull <= 1'b1;
    w(H);
    scl <= 1'b0;
    w(2);
  endtask
  // Stop: data rises while the clock is high.
  task automatic sp();
    pull <= 1'b1;
    w(H);
    scl <= 1'b1;
    w(H);
    pull <= 1'b0;
    w(H);
  endtask
  // Data moves two cycles into the low phase, never beside a clock edge.
  task automatic bit1(input logic v, output logic r);
    pull <= !v;
    w(H);
    scl <= 1'b1;
    w(H);
    r = sda_w;
    scl <= 1'b0;
    w(2);
  endtask
  // Byte msb first plus the ninth clock; 8'hFF reads, a one answers not-acknowledge.
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] d, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit1(b[i], d[i]);
    end
    bit1(a, k);
  endtask
endmodule // cog_smb_host

// ### cog_clkctl_tb_top.sv
// Self-checking testbench for the clock control bank.
`timescale 1ns/1ps
module cog_clkctl_tb_top import cog_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic power_down_pin = 1'b0;
  logic bus_clock_halt_n = 1'b1;
  logic host_clock_halt_n = 1'b1;
  logic sw_bus_halt_n = 1'b1;
  logic scl, pull, sda_out, sda_oe;
  cog_run_t run;
  int n_mismatch = 0;
  int num_checks = 0;
  localparam logic [7:0] WA = {COG_DEV_ADDR, 1'b0};
  localparam logic [7:0] RA = {COG_DEV_ADDR, 1'b1};
  localparam logic [7:0] RST [6] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h07};
  // Open-drain data wire with a pull-up: low while either party pulls.
  wire sda_w = !(sda_oe || pull);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  cog_clkctl_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_w),
    .power_down_pin(power_down_pin), .bus_clock_halt_n(bus_clock_halt_n),
    .host_clock_halt_n(host_clock_halt_n), .sw_bus_halt_n(sw_bus_halt_n),
    .sda_out(sda_out), .sda_oe(sda_oe), .run(run));
  cog_smb_host u_host (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .pull(pull));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Byte write; ex holds the expected acknowledges of address, command and data.
  task automatic wr(input logic [7:0] a, c, v, input logic [2:0] ex);
    logic [7:0] d;
    logic [2:0] k;
    u_host.st();
    u_host.xfer(a, 1'b1, d, k[2]);
    u_host.xfer(c, 1'b1, d, k[1]);
    u_host.xfer(v, 1'b1, d, k[0]);
    u_host.sp();
    chk({9'h000, k}, {9'h000, ~ex});
  endtask
  // Byte read; the last byte is answered with not-acknowledge.
  task automatic rd(input logic [6:0] o, input logic [7:0] ex);
    logic [7:0] d;
    logic [3:0] k;
    u_host.st();
    u_host.xfer(WA, 1'b1, d, k[3]);
    u_host.xfer({1'b1, o}, 1'b1, d, k[2]);
    u_host.st();
    u_host.xfer(RA, 1'b1, d, k[1]);
    u_host.xfer(8'hFF, 1'b1, d, k[0]);
    u_host.sp();
    chk({k[3:1], d}, {3'h0, ex});
  endtask
  // Pins change together; eight cycles outlast the synchronisers.
  task automatic pins(input logic [2:0] v);
    {power_down_pin, bus_clock_halt_n, host_clock_halt_n} <= v;
    u_host.w(8);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    $display("Error at %0t: run did not finish", $time);
    report_and_stop();
  end

  initial begin
    logic [7:0] d;
    logic k;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    u_host.w(4);
    for (int i = 0; i < 6; i++) begin
      rd(i[6:0], RST[i]);
    end
    wr(WA, 8'h81, 8'hA5, 3'h7);
    rd(7'h01, 8'hA5);
    chk({run.panel_run, run.serial_ref_run}, 12'h1A5);
    wr(WA, 8'h82, 8'hDA, 3'h7);
    chk({run.freerun_bus_clk_a_run, run.usb_rate_run, run.refclk_b_run}, 12'h005);
    chk({run.dot_run, run.video_nonspread_run, run.refclk_a_run, run.host_spread_on},
      12'h00E);
    wr(WA, 8'h83, 8'h50, 3'h7);
    chk({run.bus_clk_run, 1'b0, run.host_run}, 12'h051);
    rd(7'h03, 8'h50);
    wr(WA, 8'h84, 8'h0F, 3'h7);
    wr(WA, 8'h85, 8'h09, 3'h7);
    sw_bus_halt_n <= 1'b0;
    pins(3'b010);
    chk(run.serial_ref_run, 8'hA0);
    chk({run.panel_run, run.freerun_bus_clk_a_run, run.host_run}, 12'h000);
    // The pci-stop pin alone stops the same group, while the host group runs again.
    sw_bus_halt_n <= 1'b1;
    pins(3'b001);
    chk(run.serial_ref_run, 8'hA0);
    chk({run.freerun_bus_clk_a_run, run.host_run}, 12'h001);
    pins(3'b011);
    // A start in mid data byte must leave the register untouched.
    u_host.st();
    u_host.xfer(WA, 1'b1, d, k);
    u_host.xfer(8'h81, 1'b1, d, k);
    for (int i = 0; i < 4; i++) begin
      u_host.bit1(1'b0, k);
    end
    u_host.st();
    u_host.sp();
    rd(7'h01, 8'hA5);
    wr(8'hD0, 8'h81, 8'h00, 3'h0);
    wr(WA, 8'h01, 8'h00, 3'h4);
    rd(7'h01, 8'hA5);
    // An offset past the bank is acknowledged but must not alias onto register 0.
    wr(WA, 8'h88, 8'h5A, 3'h7);
    rd(7'h08, 8'h00);
    wr(WA, 8'h85, 8'h80, 3'h7);
    pins(3'b111);
    chk({run.panel_hiz, run.dot_hiz}, 12'h002);
    pins(3'b011);
    rd(7'h01, 8'hA5);
    wr(WA, 8'h85, 8'h40, 3'h7);
    pins(3'b111);
    chk({run.panel_hiz, run.dot_hiz}, 12'h001);
    pins(3'b011);
    pins(3'b100);
    pins(3'b011);
    rd(7'h00, 8'h11);
    chk(run.mgmt_mode_select, 12'h001);
    wr(WA, 8'h80, 8'h00, 3'h7);
    chk(run.mgmt_mode_select, 12'h000);
    pins(3'b111);
    pins(3'b011);
    rd(7'h01, 8'hFF);
    rd(7'h00, 8'h01);
    report_and_stop();
  end
endmodule // cog_clkctl_tb_top
